// >>> rtl/gbe_master_slave_config.sv
/*
 * gbe_master_slave_config: AXI4-Lite register bank for the gigabit
 * master/slave role control, with deferred commit into an active shadow.
 * assumes: link_up_i is synchronous to clk_i; the host keeps AXI4-Lite
 * valid/payload stable until taken and runs one write and one read at a time.
 */
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module gbe_master_slave_config #(
	parameter int ADDR_W = 8  // byte address width
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          ce_i,
	// axi4-lite write address
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	// axi4-lite write data
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	// axi4-lite write response
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	output logic [1:0]                         s_axi_bresp,
	// axi4-lite read address
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	// axi4-lite read data
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	// link side
	input  wire logic                          link_up_i,
	output logic                               pdown_o,
	output logic                               soft_reset_o,
	output logic                               restart_an_o,
	output logic                               commit_o,
	output logic [role_cfg_pkg::FLD_W-1:0]     active_cfg_o,
	output logic                               force_master_o,
	output logic                               force_slave_o,
	output logic                               prefer_master_o,
	output logic                               adv_full_o
);
	import role_cfg_pkg::*;

	// the highest register must fit in the address
	if (ADDR_W < IDX_W + IDX_LSB) begin : g_bad_addr
		$error("ADDR_W too small for register map");
	end

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,  // gathering address and data
		WR_RESP    = 2'b10   // response offered
	} wr_state_t;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,  // ready for an address
		RD_DATA = 2'b10   // data offered
	} rd_state_t;

	wr_state_t   wr_state_q;   // write channel state
	rd_state_t   rd_state_q;   // read channel state
	logic        aw_got_q;     // write address held
	logic        w_got_q;      // write data held
	logic [IDX_W-1:0] aw_idx_q; // held write index
	logic        aw_hit_q;     // held address in range of index bits
	logic [31:0] wdata_q;      // held write data
	logic [3:0]  wstrb_q;      // held strobes
	logic [15:0] basic_q;      // basic control readback
	logic [15:0] role_q;       // role control readback
	logic        link_seen_q;  // last link level for status

	logic        aw_hs;        // address taken this edge
	logic        w_hs;         // data taken this edge
	logic        wr_fire;      // write performed this edge
	logic [IDX_W-1:0] wr_idx;  // index in effect
	logic        wr_hit;       // upper address bits clear
	logic [31:0] wr_data;      // data in effect
	logic [3:0]  wr_strb;      // strobes in effect
	logic [15:0] basic_new;    // basic control after merge
	logic        wr_basic;     // write lands on basic control
	logic        wr_role;      // write lands on role control
	logic        wr_ok;        // write address mapped
	logic        link_drop;    // link fell this edge
	logic [FLD_W-1:0] act_cfg; // shadow fields

	// true when the address bits above the index are all zero
	function automatic logic upper_clear(input logic [ADDR_W-1:0] a);
		return (a >> (IDX_W + IDX_LSB)) == '0;
	endfunction

	// index field of a byte address
	function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
		return a[IDX_LSB +: IDX_W];
	endfunction

	// only mapped indices answer okay
	function automatic logic mapped(input logic hit, input logic [IDX_W-1:0] i);
		return hit && (i == BASIC_IDX || i == ROLE_IDX || i == STAT_IDX);
	endfunction

	// handshakes are combinational from state; holding both beats is free
	// all gated by ce_i: a beat taken while frozen would be lost or repeated
	assign s_axi_awready = ce_i && (wr_state_q == WR_COLLECT) && !aw_got_q;
	assign s_axi_wready  = ce_i && (wr_state_q == WR_COLLECT) && !w_got_q;
	assign s_axi_bvalid  = ce_i && (wr_state_q == WR_RESP);
	assign s_axi_arready = ce_i && (rd_state_q == RD_IDLE);
	assign s_axi_rvalid  = ce_i && (rd_state_q == RD_DATA);

	assign aw_hs   = s_axi_awvalid && s_axi_awready;
	assign w_hs    = s_axi_wvalid && s_axi_wready;
	assign wr_fire = ce_i && (wr_state_q == WR_COLLECT)
		&& (aw_got_q || aw_hs) && (w_got_q || w_hs);

	// use what arrives now or what was held, whichever came
	assign wr_idx  = aw_got_q ? aw_idx_q : idx_of(s_axi_awaddr);
	assign wr_hit  = aw_got_q ? aw_hit_q : upper_clear(s_axi_awaddr);
	assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
	assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
	assign wr_ok   = mapped(wr_hit, wr_idx);
	assign wr_basic = wr_fire && wr_hit && (wr_idx == BASIC_IDX);
	assign wr_role  = wr_fire && wr_hit && (wr_idx == ROLE_IDX);
	assign basic_new = merge16(basic_q, wr_data, wr_strb);

	// command pulses come straight from the write that carries them
	assign soft_reset_o = wr_basic && basic_new[BC_SWRESET];
	assign restart_an_o = wr_basic && basic_new[BC_RESTART];
	// commit events; a drop coinciding with a role write loads the old value
	assign commit_o = soft_reset_o || restart_an_o
		|| (wr_basic && basic_q[BC_PDOWN] && !basic_new[BC_PDOWN])
		|| link_drop;

	// write channel sequencing
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_state_q  <= WR_COLLECT;
			aw_got_q    <= 1'b0;
			w_got_q     <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce_i) begin
			unique case (wr_state_q)
				WR_COLLECT: begin
					if (wr_fire) begin
						wr_state_q  <= WR_RESP;
						aw_got_q    <= 1'b0;
						w_got_q     <= 1'b0;
						s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
					end else begin
						aw_got_q <= aw_got_q || aw_hs;
						w_got_q  <= w_got_q || w_hs;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_q <= WR_COLLECT;
					end
				end
			endcase
		end
	end

	// held copies of whichever half came first
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_idx_q <= '0;
			aw_hit_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (ce_i) begin
			if (aw_hs) begin
				aw_idx_q <= idx_of(s_axi_awaddr);
				aw_hit_q <= upper_clear(s_axi_awaddr);
			end
			if (w_hs) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// register contents; self-clearing bits never stick
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			basic_q <= BASIC_RST;
			role_q  <= ROLE_RST;
		end else if (ce_i) begin
			if (wr_basic) begin
				// only power-down is kept; reset and restart self-clear
				basic_q <= basic_new & (16'h0001 << BC_PDOWN);
			end
			if (wr_role) begin
				// fields 12:9 only; test mode and reserved stay zero
				role_q <= merge16(role_q, wr_data, wr_strb)
					& (16'h000f << RC_ADVFULL);
			end
		end
	end
	assign pdown_o = basic_q[BC_PDOWN];

	// link level kept for the status word
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link_seen_q <= 1'b0;
		end else if (ce_i) begin
			link_seen_q <= link_up_i;
		end
	end

	// read channel: data registered, answered one edge after address
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_state_q  <= RD_IDLE;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce_i) begin
			unique case (rd_state_q)
				RD_IDLE: begin
					if (s_axi_arvalid) begin
						rd_state_q  <= RD_DATA;
						s_axi_rresp <= mapped(upper_clear(s_axi_araddr),
							idx_of(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
						if (!upper_clear(s_axi_araddr)) begin
							s_axi_rdata <= '0;
						end else if (idx_of(s_axi_araddr) == BASIC_IDX) begin
							s_axi_rdata <= {16'h0000, basic_q};
						end else if (idx_of(s_axi_araddr) == ROLE_IDX) begin
							s_axi_rdata <= {16'h0000, role_q};
						end else if (idx_of(s_axi_araddr) == STAT_IDX) begin
							// shows what negotiation really uses
							s_axi_rdata <= {16'h0000, 3'h0, act_cfg, 7'h00,
								basic_q[BC_PDOWN], link_seen_q};
						end else begin
							s_axi_rdata <= '0;
						end
					end
				end
				RD_DATA: begin
					if (s_axi_rready) begin
						rd_state_q <= RD_IDLE;
					end
				end
			endcase
		end
	end

	link_drop_detect u_drop (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.link_up_i (link_up_i),
		.drop_o    (link_drop)
	);

	// negotiation sees only this copy, never role_q directly
	role_shadow u_shadow (
		.clk_i           (clk_i),
		.rst_n_i         (rst_n_i),
		.ce_i            (ce_i),
		.commit_i        (commit_o),
		.pend_i          (role_q[RC_ADVFULL +: FLD_W]),
		.act_o           (act_cfg),
		.force_master_o  (force_master_o),
		.force_slave_o   (force_slave_o),
		.prefer_master_o (prefer_master_o),
		.adv_full_o      (adv_full_o)
	);
	assign active_cfg_o = act_cfg;

	sequence s_role_write;
		wr_role && !commit_o;
	endsequence

	a_role_readback: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_role_write |=> role_q == ($past(merge16(role_q, wr_data, wr_strb))
			& (16'h000f << RC_ADVFULL)) && $stable(act_cfg))
		else $error("role write not shown or applied early");
	a_swreset_commit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		soft_reset_o |=> act_cfg == $past(role_q[RC_ADVFULL +: FLD_W]))
		else $error("soft reset did not commit");
	a_restart_commit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		restart_an_o |-> commit_o ##1 act_cfg == $past(role_q[RC_ADVFULL +: FLD_W]))
		else $error("restart did not commit");
	a_pdown_commit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && $fell(basic_q[BC_PDOWN]) |-> $past(commit_o))
		else $error("power-up without commit");
	a_role_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> role_q == ROLE_RST && act_cfg == FLD_RST
			&& adv_full_o && !force_master_o && !prefer_master_o)
		else $error("role reset values wrong");
endmodule
`default_nettype wire

// >>> rtl/link_drop_detect.sv
/*
 * link_drop_detect: turns the link status level into a one-cycle pulse
 * on each up-to-down transition.
 * assumes: link_up_i is synchronous to clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module link_drop_detect (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	input  wire logic link_up_i,
	output logic      drop_o
);
	import role_cfg_pkg::*;

	logic link_q;  // last sampled level

	// remembered level; starts low so power-up never reads as a drop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link_q <= 1'b0;
		end else if (ce_i) begin
			link_q <= link_up_i;
		end
	end

	// pulse only while enabled, so a frozen block sees no event
	assign drop_o = ce_i & link_q & ~link_up_i;

	a_drop_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && link_up_i) ##1 (ce_i && !link_up_i) |-> drop_o)
		else $error("link drop gave no pulse");
endmodule
`default_nettype wire

// >>> rtl/role_cfg_pkg.sv
/*
 * role_cfg_pkg: register indices, field positions, reset values and bus codes
 * for the gigabit role configuration block.
 * assumes: a 32-bit AXI4-Lite slave with one register per aligned word.
 */
package role_cfg_pkg;
	// register indices; byte address is four times the index
	localparam logic [4:0]  BASIC_IDX    = 5'h00;  // basic control
	localparam logic [4:0]  ROLE_IDX     = 5'h09;  // gigabit_role_control
	localparam logic [4:0]  STAT_IDX     = 5'h1f;  // active setting readback
	localparam int          IDX_LSB      = 2;      // word index starts above byte bits
	localparam int          IDX_W        = 5;      // bits of index decoded
	// basic control fields
	localparam int          BC_SWRESET   = 15;     // self-clearing soft reset
	localparam int          BC_PDOWN     = 11;     // power-down
	localparam int          BC_RESTART   = 9;      // self-clearing restart
	// role control fields, also the layout of the status word
	localparam int          RC_MANUAL    = 12;     // manual selection enable
	localparam int          RC_VALUE     = 11;     // manual role, 1 = master
	localparam int          RC_PORT      = 10;     // port type, 1 = multi-port
	localparam int          RC_ADVFULL   = 9;      // advertise 1000 full duplex
	localparam int          FLD_W        = 4;      // fields 12:9
	// status word extras
	localparam int          ST_LINK      = 0;      // link up seen
	localparam int          ST_PDOWN     = 1;      // power-down held
	// reset values
	localparam logic [15:0] BASIC_RST    = 16'h0000;
	localparam logic [15:0] ROLE_RST     = 16'h0200;
	localparam logic [3:0]  FLD_RST      = 4'h1;   // fields 12:9 of ROLE_RST
	// axi responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// merge 16-bit register with write data under byte strobes
	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [15:0] r;
		r = old_v;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction
endpackage

// >>> rtl/role_shadow.sv
/*
 * role_shadow: active copy of the role fields, loaded only on commit,
 * and the role decisions handed to the negotiation logic.
 * assumes: commit_i is a one-cycle pulse; pend_i is the readback copy.
 */
`timescale 1ns/1ns
`default_nettype none
module role_shadow (
	input  wire logic                          clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          ce_i,
	input  wire logic                          commit_i,
	input  wire logic [role_cfg_pkg::FLD_W-1:0] pend_i,
	output logic      [role_cfg_pkg::FLD_W-1:0] act_o,
	output logic                               force_master_o,
	output logic                               force_slave_o,
	output logic                               prefer_master_o,
	output logic                               adv_full_o
);
	import role_cfg_pkg::*;

	localparam int M = RC_MANUAL - RC_ADVFULL;  // field offsets within pend_i
	localparam int V = RC_VALUE - RC_ADVFULL;
	localparam int P = RC_PORT - RC_ADVFULL;

	// shadow and decisions all come from flops, loaded together
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			act_o           <= FLD_RST;
			force_master_o  <= 1'b0;
			force_slave_o   <= 1'b0;
			prefer_master_o <= 1'b0;
			adv_full_o      <= 1'b1;
		end else if (ce_i && commit_i) begin
			act_o           <= pend_i;
			// manual value only counts when manual is on
			force_master_o  <= pend_i[M] & pend_i[V];
			force_slave_o   <= pend_i[M] & ~pend_i[V];
			// port type only counts in automatic mode
			prefer_master_o <= ~pend_i[M] & pend_i[P];
			adv_full_o      <= pend_i[0];
		end
	end

	sequence s_commit;
		ce_i && commit_i;
	endsequence

	a_commit_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_commit |=> act_o == $past(pend_i))
		else $error("shadow not loaded on commit");
	a_hold_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!(ce_i && commit_i) |=> $stable(act_o) && $stable(adv_full_o))
		else $error("shadow changed without commit");
	a_manual_role: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_commit ##0 pend_i[M] |=> force_master_o == $past(pend_i[V])
			&& force_slave_o != force_master_o)
		else $error("manual role not forced");
	a_value_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_commit ##0 !pend_i[M] |=> !force_master_o && !force_slave_o)
		else $error("manual value used in auto mode");
	a_port_pref: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_commit ##0 !pend_i[M] |=> prefer_master_o == $past(pend_i[P]))
		else $error("port preference not applied");
	a_port_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_commit ##0 pend_i[M] |=> !prefer_master_o)
		else $error("port preference used in manual mode");
	a_adv_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		adv_full_o == act_o[0])
		else $error("advertisement differs from shadow");
endmodule
`default_nettype wire

// >>> tb/axi_host_model.sv
/*
 * axi_host_model: management host that reaches the role registers over
 * AXI4-Lite, one write and one read at a time, offered by calling its tasks.
 * assumes: a single clock, and a slave that answers each transfer in time.
 */
`timescale 1ns/1ns
`default_nettype none
module axi_host_model (
	input  wire logic        clk_i,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [7:0]       awaddr_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	input  wire logic [1:0]  bresp_i,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	output logic [7:0]       araddr_o,
	input  wire logic        rvalid_i,
	output logic             rready_o,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i
);
	// idle bus from time zero
	initial begin
		awvalid_o = 1'b0;
		awaddr_o  = 8'h00;
		wvalid_o  = 1'b0;
		wdata_o   = 32'h0000_0000;
		wstrb_o   = 4'h0;
		bready_o  = 1'b0;
		arvalid_o = 1'b0;
		araddr_o  = 8'h00;
		rready_o  = 1'b0;
	end

	// address and data offered together, each dropped once taken
	task automatic write_word(input logic [7:0] addr, input logic [31:0] data,
		output logic [1:0] resp);
		logic aw_pend;
		logic w_pend;
		@(posedge clk_i);
		awaddr_o  <= addr;
		awvalid_o <= 1'b1;
		wdata_o   <= data;
		wstrb_o   <= 4'hf;
		wvalid_o  <= 1'b1;
		bready_o  <= 1'b1;
		aw_pend = 1'b1;
		w_pend  = 1'b1;
		while (aw_pend || w_pend) begin
			@(posedge clk_i);
			// pre-edge ready decides whether the item moved
			if (aw_pend && awready_i) begin
				awvalid_o <= 1'b0;
				aw_pend = 1'b0;
			end
			if (w_pend && wready_i) begin
				wvalid_o <= 1'b0;
				w_pend = 1'b0;
			end
		end
		// bready stays up until the answer is seen
		do @(posedge clk_i); while (bvalid_i !== 1'b1);
		resp = bresp_i;
		bready_o <= 1'b0;
	endtask

	// read request, rready held until rvalid is sampled
	task automatic read_word(input logic [7:0] addr, output logic [31:0] data,
		output logic [1:0] resp);
		@(posedge clk_i);
		araddr_o  <= addr;
		arvalid_o <= 1'b1;
		rready_o  <= 1'b1;
		do @(posedge clk_i); while (arready_i !== 1'b1);
		arvalid_o <= 1'b0;
		do @(posedge clk_i); while (rvalid_i !== 1'b1);
		data = rdata_i;
		resp = rresp_i;
		rready_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb/gbe_master_slave_config_test.sv
/*
 * gbe_master_slave_config_test: register sequences through the host model,
 * checking readback, deferred commit and the role decisions.
 * assumes: axi_host_model and the role_cfg_pkg design files are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module gbe_master_slave_config_test;
	import role_cfg_pkg::*;
	logic        clk_i;      // 20 MHz
	logic        rst_n_i;    // async, active low
	logic        ce_i;       // enabled except during the frozen link-pulse step
	logic        link_up_i;  // link level
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        pdown_o, soft_reset_o, restart_an_o, commit_o;
	logic        force_master_o, force_slave_o, prefer_master_o, adv_full_o;
	logic [3:0]  active_cfg_o;
	int          num_errors  = 0;
	int          check_count = 0;
	int          commits     = 0;  // commit pulses seen
	int          soft_resets = 0;  // soft reset pulses seen
	int          restarts    = 0;  // restart pulses seen

	gbe_master_slave_config #(.ADDR_W(8)) u_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .link_up_i(link_up_i), .pdown_o(pdown_o),
		.soft_reset_o(soft_reset_o), .restart_an_o(restart_an_o), .commit_o(commit_o),
		.active_cfg_o(active_cfg_o), .force_master_o(force_master_o),
		.force_slave_o(force_slave_o), .prefer_master_o(prefer_master_o),
		.adv_full_o(adv_full_o));

	axi_host_model u_host (
		.clk_i(clk_i), .awvalid_o(awvalid), .awready_i(awready), .awaddr_o(awaddr),
		.wvalid_o(wvalid), .wready_i(wready), .wdata_o(wdata), .wstrb_o(wstrb),
		.bvalid_i(bvalid), .bready_o(bready), .bresp_i(bresp), .arvalid_o(arvalid),
		.arready_i(arready), .araddr_o(araddr), .rvalid_i(rvalid), .rready_o(rready),
		.rdata_i(rdata), .rresp_i(rresp));

	// clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// pulse counters; combinational pulses are sampled at the edge they launch
	always @(posedge clk_i) begin
		if (commit_o === 1'b1) commits++;
		if (soft_reset_o === 1'b1) soft_resets++;
		if (restart_an_o === 1'b1) restarts++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t value mismatch: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// role outputs expected from the four committed fields {manual,value,port,adv}
	task automatic check_cfg(input logic [3:0] f);
		@(negedge clk_i);
		check({24'h0, active_cfg_o, force_master_o, force_slave_o, prefer_master_o,
			adv_full_o}, {24'h0, f, f[3] & f[2], f[3] & ~f[2], ~f[3] & f[1], f[0]});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		u_host.write_word(a, d, r);
		check({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		u_host.read_word(a, d, r);
		check(d, ed);
		check({30'h0, r}, {30'h0, er});
	endtask

	task automatic give_verdict;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// watchdog, far beyond the fewer than a hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		give_verdict();
	end

	// main sequence
	initial begin
		rst_n_i   = 1'b0;
		ce_i      = 1'b1;
		link_up_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		check_cfg(4'h1);
		rd(8'h24, 32'h0000_0200, RESP_OKAY);
		// manual master written but not yet active
		wr(8'h24, 32'h0000_1800, RESP_OKAY);
		rd(8'h24, 32'h0000_1800, RESP_OKAY);
		check_cfg(4'h1);
		check(commits, 0);
		// restart negotiation commits it
		wr(8'h00, 32'h0000_0200, RESP_OKAY);
		check_cfg(4'hc);
		check(restarts, 1);
		// manual slave with port type set, committed by soft reset
		wr(8'h24, 32'h0000_1400, RESP_OKAY);
		wr(8'h00, 32'h0000_8000, RESP_OKAY);
		check_cfg(4'ha);
		check(soft_resets, 1);
		rd(8'h00, 32'h0000_0000, RESP_OKAY);
		// entering power-down does not commit, leaving it does
		wr(8'h24, 32'h0000_0600, RESP_OKAY);
		wr(8'h00, 32'h0000_0800, RESP_OKAY);
		check({31'h0, pdown_o}, 32'h1);
		check_cfg(4'ha);
		check(commits, 2);
		wr(8'h00, 32'h0000_0000, RESP_OKAY);
		check_cfg(4'h3);
		check(commits, 3);
		// automatic mode with manual value set; link drop commits
		wr(8'h24, 32'h0000_0800, RESP_OKAY);
		check_cfg(4'h3);
		@(posedge clk_i);
		link_up_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		link_up_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check_cfg(4'h4);
		check(commits, 4);
		rd(8'h7c, 32'h0000_0800, RESP_OKAY);
		// a link pulse while the block is frozen is never seen
		ce_i      <= 1'b0;
		link_up_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		link_up_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		ce_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check(commits, 4);
		check_cfg(4'h4);
		// unmapped word refused and leaves the role register alone
		wr(8'h10, 32'h0000_ffff, RESP_SLVERR);
		rd(8'h10, 32'h0000_0000, RESP_SLVERR);
		rd(8'h24, 32'h0000_0800, RESP_OKAY);
		give_verdict();
	end
endmodule
`default_nettype wire
